/* hdl/alert_regs.svh */
`ifndef ALERT_REGS_SVH
`define ALERT_REGS_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define IDX_ALERT_MASK_ONE 8'h74
`define IDX_ALERT_MASK_TWO 8'h75
`define IDX_VOLTAGE_LOW_BITS 8'h76
`define IDX_TEMPERATURE_LOW_BITS 8'h77
`define IDX_ALERT_CONFIG 8'h78
`define IDX_HIGH_BYTE_BASE 8'h80

// ********************************************************************
// reset values and writable bits
// ********************************************************************
`define MASK_ONE_RESET 8'h00
`define MASK_TWO_RESET 8'h00
`define CONFIG_RESET 1'b0
`define MASK_ONE_WRITABLE 8'hF6
`define MASK_TWO_WRITABLE 8'hFC

// ********************************************************************
// field positions
// ********************************************************************
`define M1_CORE_VOLTAGE 1
`define M1_SUPPLY_VOLTAGE 2
`define M1_REMOTE_ONE_TEMP 4
`define M1_LOCAL_TEMP 5
`define M1_REMOTE_TWO_TEMP 6
`define M1_STATUS_TWO_OVERRIDE 7
`define M2_OVERTEMPERATURE 1
`define M2_FOURTH_FAN_OR_TIMER 5
`define M2_REMOTE_TWO_DIODE 7
`define ALERT_ENABLE_BIT 0

// ********************************************************************
// channels, widths, bus answers
// ********************************************************************
`define NUM_CHANNELS 5
`define READING_WIDTH 10
`define CH_CORE_VOLTAGE 0
`define CH_SUPPLY_VOLTAGE 1
`define CH_REMOTE_ONE_TEMP 2
`define CH_LOCAL_TEMP 3
`define CH_REMOTE_TWO_TEMP 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* hdl/alert_pkg.sv */
`include "alert_regs.svh"

package alert_pkg;

  typedef struct packed {
    logic remote_two_temp;
    logic local_temp;
    logic remote_one_temp;
    logic supply_voltage;
    logic core_voltage;
  } limit_events_s;

  typedef struct packed {
    logic diode_two;
    logic diode_one;
    logic timer_event;
    logic fan_four;
    logic fan_three;
    logic fan_two;
    logic fan_one;
    logic overtemp;
  } fault_events_s;

  typedef struct packed {
    logic [`NUM_CHANNELS-1:0] valid;
    logic [`NUM_CHANNELS-1:0][`READING_WIDTH-1:0] data;
  } readings_s;

  typedef struct packed {
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] mask_one;
    logic [7:0] mask_two;
    logic alert_en;
    logic alert_n;
    logic alert_oe;
  } regs_s;

endpackage : alert_pkg

/* hdl/reading_holder.sv */
`include "alert_regs.svh"
module reading_holder
  import alert_pkg::*;
#(
  parameter int W = `READING_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample_data,
  input wire logic freeze_set,
  input wire logic freeze_clr,
  output logic [W-1:0] value_q,
  output logic frozen_q
);

  typedef struct packed {
    logic frozen;
    logic [W-1:0] value;
  } holder_s;

  holder_s st_q;
  holder_s st_d;

  always_comb begin
    st_d = st_q;
    // no update on the edge that sets the freeze
    if (sample_valid && !st_q.frozen && !freeze_set) begin
      st_d.value = sample_data;
    end
    if (freeze_set) begin
      st_d.frozen = 1'b1;
    end else if (freeze_clr) begin
      st_d.frozen = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign value_q = st_q.value;
  assign frozen_q = st_q.frozen;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_hold_stable;
    (frozen_q || freeze_set) && !freeze_clr |=> $stable(value_q);
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("frozen reading changed");

endmodule : reading_holder

/* hdl/alert_mask_and_ext_resolution.sv */
// Functional notes
// - mask one bits block limit alerts
// - mask one bit 7 clear overrides full mask two
// - overtemperature mask bit is read only
// - mask two bits 2-4 block fan faults
// - mask two bit 5 fan four or timer
// - mask two bits 6-7 block diode faults
// - both mask registers reset to zero
// - voltage low bits in fields 3:2, 5:4
// - temperature low bits in 3:2, 5:4, 7:6
// - low bits read freezes readings until read
// - alert pin only when config bit 0 set
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "alert_regs.svh"
module alert_mask_and_ext_resolution
  import alert_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire limit_events_s limit_events,
  input wire fault_events_s fault_events,
  input wire logic tach_pin_is_thermal,
  input wire readings_s new_readings,
  output logic alert_n,
  output logic alert_oe
);

  localparam int NCH = `NUM_CHANNELS;
  localparam int RW = `READING_WIDTH;

  regs_s st_q;
  regs_s st_d;
  logic [NCH-1:0][RW-1:0] value;
  logic [NCH-1:0] frozen;
  logic [NCH-1:0] freeze_set;
  logic [NCH-1:0] freeze_clr;
  logic [4:0] limit_mask;
  logic [7:1] fault_src;
  logic lim_unmasked;
  logic fault_unmasked;
  logic override_alert;
  logic alert_any;
  logic rd_ok;
  logic [7:0] rd_val;
  logic wr_fire;
  logic rd_fire;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  // ********************************************************************
  // reading holders
  // ********************************************************************
  for (genvar i = 0; i < NCH; i++) begin : g_hold
    reading_holder #(
      .W(RW)
    ) u_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_valid(new_readings.valid[i]),
      .sample_data(new_readings.data[i]),
      .freeze_set(freeze_set[i]),
      .freeze_clr(freeze_clr[i]),
      .value_q(value[i]),
      .frozen_q(frozen[i])
    );
  end

  // ********************************************************************
  // alert combine
  // ********************************************************************
  always_comb begin
    limit_mask = {st_q.mask_one[`M1_REMOTE_TWO_TEMP],
                  st_q.mask_one[`M1_LOCAL_TEMP],
                  st_q.mask_one[`M1_REMOTE_ONE_TEMP],
                  st_q.mask_one[`M1_SUPPLY_VOLTAGE],
                  st_q.mask_one[`M1_CORE_VOLTAGE]};
    lim_unmasked = |(limit_events & ~limit_mask);
    fault_src = {fault_events.diode_two, fault_events.diode_one,
                 tach_pin_is_thermal ? fault_events.timer_event
                                     : fault_events.fan_four,
                 fault_events.fan_three, fault_events.fan_two,
                 fault_events.fan_one, fault_events.overtemp};
    fault_unmasked = |(fault_src & ~st_q.mask_two[7:1]);
    override_alert = (&st_q.mask_two[7:2]) && (|fault_src)
      && !st_q.mask_one[`M1_STATUS_TWO_OVERRIDE];
    alert_any = lim_unmasked || fault_unmasked || override_alert;
  end

  // ********************************************************************
  // register read decode
  // ********************************************************************
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 8'h00;
    freeze_set = '0;
    freeze_clr = '0;
    rd_fire = arvalid && st_q.arready;
    if (araddr == byte_addr(`IDX_ALERT_MASK_ONE)) begin
      rd_val = st_q.mask_one;
    end else if (araddr == byte_addr(`IDX_ALERT_MASK_TWO)) begin
      rd_val = st_q.mask_two;
    end else if (araddr == byte_addr(`IDX_VOLTAGE_LOW_BITS)) begin
      rd_val = {2'b00, value[`CH_SUPPLY_VOLTAGE][1:0],
                value[`CH_CORE_VOLTAGE][1:0], 2'b00};
      freeze_set[`CH_SUPPLY_VOLTAGE] = rd_fire;
      freeze_set[`CH_CORE_VOLTAGE] = rd_fire;
    end else if (araddr == byte_addr(`IDX_TEMPERATURE_LOW_BITS)) begin
      rd_val = {value[`CH_REMOTE_TWO_TEMP][1:0],
                value[`CH_LOCAL_TEMP][1:0],
                value[`CH_REMOTE_ONE_TEMP][1:0], 2'b00};
      freeze_set[`CH_REMOTE_TWO_TEMP] = rd_fire;
      freeze_set[`CH_LOCAL_TEMP] = rd_fire;
      freeze_set[`CH_REMOTE_ONE_TEMP] = rd_fire;
    end else if (araddr == byte_addr(`IDX_ALERT_CONFIG)) begin
      rd_val = {7'h00, st_q.alert_en};
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < NCH; i++) begin
        if (araddr == byte_addr(`IDX_HIGH_BYTE_BASE + 8'(i))) begin
          rd_ok = 1'b1;
          rd_val = value[i][RW-1:2];
          freeze_clr[i] = rd_fire;
        end
      end
    end
  end

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_d = st_q;
    wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    if (awvalid && st_q.awready) begin
      st_d.aw_held = 1'b1;
      st_d.awaddr = 12'(awaddr);
    end
    if (wvalid && st_q.wready) begin
      st_d.w_held = 1'b1;
      st_d.wbyte = wdata[7:0];
      st_d.wlane = wstrb[0];
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `RESP_OKAY;
      if (ADDR_W'(st_q.awaddr) == byte_addr(`IDX_ALERT_MASK_ONE)) begin
        if (st_q.wlane) begin
          st_d.mask_one = st_q.wbyte & `MASK_ONE_WRITABLE;
        end
      end else if (ADDR_W'(st_q.awaddr) ==
                   byte_addr(`IDX_ALERT_MASK_TWO)) begin
        if (st_q.wlane) begin
          st_d.mask_two = st_q.wbyte & `MASK_TWO_WRITABLE;
        end
      end else if (ADDR_W'(st_q.awaddr) ==
                   byte_addr(`IDX_ALERT_CONFIG)) begin
        if (st_q.wlane) begin
          st_d.alert_en = st_q.wbyte[`ALERT_ENABLE_BIT];
        end
      end else if (ADDR_W'(st_q.awaddr) ==
                   byte_addr(`IDX_VOLTAGE_LOW_BITS)
                   || ADDR_W'(st_q.awaddr) ==
                   byte_addr(`IDX_TEMPERATURE_LOW_BITS)) begin
        st_d.bresp = `RESP_OKAY;
      end else begin
        st_d.bresp = `RESP_SLVERR;
      end
    end
    st_d.awready = !st_d.aw_held && !st_d.bvalid;
    st_d.wready = !st_d.w_held && !st_d.bvalid;
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = {24'h00_0000, rd_val};
      st_d.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    st_d.arready = !st_d.rvalid;
    st_d.alert_n = !(st_q.alert_en && alert_any);
    st_d.alert_oe = st_q.alert_en && alert_any;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.mask_one <= `MASK_ONE_RESET;
      st_q.mask_two <= `MASK_TWO_RESET;
      st_q.alert_en <= `CONFIG_RESET;
      st_q.alert_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign alert_n = st_q.alert_n;
  assign alert_oe = st_q.alert_oe;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_mask_reset;
    $past(rst) |-> st_q.mask_one == 8'h00 && st_q.mask_two == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("masks not zero after reset");

  property p_mask_one_write;
    wr_fire && st_q.wlane
      && ADDR_W'(st_q.awaddr) == byte_addr(`IDX_ALERT_MASK_ONE)
      |=> st_q.mask_one == ($past(st_q.wbyte) & `MASK_ONE_WRITABLE);
  endproperty
  a_mask_one_write: assert property (p_mask_one_write)
    else $error("mask one write lost");

  property p_overtemp_ro;
    wr_fire && ADDR_W'(st_q.awaddr) == byte_addr(`IDX_ALERT_MASK_TWO)
      |=> !st_q.mask_two[`M2_OVERTEMPERATURE];
  endproperty
  a_overtemp_ro: assert property (p_overtemp_ro)
    else $error("overtemperature mask bit changed");

  property p_core_alert;
    st_q.alert_en && limit_events.core_voltage
      && !st_q.mask_one[`M1_CORE_VOLTAGE] |=> !alert_n && alert_oe;
  endproperty
  a_core_alert: assert property (p_core_alert)
    else $error("core voltage event gave no alert");

  property p_fan_one_alert;
    st_q.alert_en && fault_events.fan_one && !st_q.mask_two[2]
      |=> !alert_n;
  endproperty
  a_fan_one_alert: assert property (p_fan_one_alert)
    else $error("fan fault gave no alert");

  property p_timer_alert;
    st_q.alert_en && tach_pin_is_thermal && fault_events.timer_event
      && !st_q.mask_two[`M2_FOURTH_FAN_OR_TIMER] |=> !alert_n;
  endproperty
  a_timer_alert: assert property (p_timer_alert)
    else $error("timer event gave no alert");

  property p_diode_alert;
    st_q.alert_en && fault_events.diode_two
      && !st_q.mask_two[`M2_REMOTE_TWO_DIODE] |=> !alert_n;
  endproperty
  a_diode_alert: assert property (p_diode_alert)
    else $error("diode fault gave no alert");

  property p_override;
    st_q.alert_en && (&st_q.mask_two[7:2]) && (|fault_src)
      && !st_q.mask_one[`M1_STATUS_TWO_OVERRIDE] |=> !alert_n;
  endproperty
  a_override: assert property (p_override)
    else $error("override clear but alert not driven");

  property p_pin_off;
    !st_q.alert_en |=> alert_n && !alert_oe;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("alert driven while function disabled");

  property p_freeze;
    rd_fire && araddr == byte_addr(`IDX_VOLTAGE_LOW_BITS)
      |=> frozen[`CH_CORE_VOLTAGE] && frozen[`CH_SUPPLY_VOLTAGE];
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("low bits read did not freeze readings");

  property p_ext_two_data;
    rd_fire && araddr == byte_addr(`IDX_TEMPERATURE_LOW_BITS)
      |=> rdata[7:6] == $past(value[`CH_REMOTE_TWO_TEMP][1:0]);
  endproperty
  a_ext_two_data: assert property (p_ext_two_data)
    else $error("remote two low bits wrong");

  property p_ext_one_data;
    rd_fire && araddr == byte_addr(`IDX_VOLTAGE_LOW_BITS)
      |=> rdata[3:2] == $past(value[`CH_CORE_VOLTAGE][1:0]);
  endproperty
  a_ext_one_data: assert property (p_ext_one_data)
    else $error("core voltage low bits wrong");

  c_override_quiet: cover property (st_q.alert_en && (&st_q.mask_two[7:2])
    && st_q.mask_one[`M1_STATUS_TWO_OVERRIDE] && (|fault_src) && alert_n);
  c_freeze_release: cover property (frozen[0] ##[1:20] !frozen[0]);
  c_alert_on: cover property ($fell(alert_n));

endmodule : alert_mask_and_ext_resolution

/* tb/sensor_model.sv */
// ****************************************
// reading source on the far side
// ****************************************
module sensor_model
  import alert_pkg::*;
#(
  parameter int STEP = 37
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [9:0] base,
  output readings_s readings
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readings <= '0;
    end else begin
      readings.valid <= fire ? 5'h1f : 5'h00;
      // stale data inverts on every cycle without fire
      for (int c = 0; c < 5; c++) begin
        readings.data[c] <= fire ? base + 10'(c * STEP) : ~readings.data[c];
      end
    end
  end
endmodule : sensor_model

/* tb/alert_mask_and_ext_resolution_bench.sv */
`include "alert_regs.svh"
module alert_mask_and_ext_resolution_bench
  import alert_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STEP = 37;
  logic ref_clk = 0, rst = 1, tach_pin_is_thermal = 0, fire = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, alert_n, alert_oe;
  logic [9:0] base = 0;
  limit_events_s limit_events = '0;
  fault_events_s fault_events = '0;
  readings_s new_readings;
  int err_total = 0, checked = 0;
  int pos [5] = '{1, 2, 4, 5, 6};

  always #10 ref_clk = ~ref_clk;

  alert_mask_and_ext_resolution i_dut (.ref_clk, .rst, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .limit_events, .fault_events, .tach_pin_is_thermal,
    .new_readings, .alert_n, .alert_oe);
  sensor_model #(.STEP(STEP)) i_src (.ref_clk, .rst, .fire, .base,
    .readings(new_readings));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba

  function automatic logic [9:0] v(input logic [9:0] b, input int c);
    return b + 10'(c * STEP);
  endfunction : v

  task automatic wr(input logic [7:0] i, input logic [31:0] dt);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= ba(i);
    wdata <= dt;
    wstrb <= 4'hf;
    while (!(aw && w) && n < 1000) begin
      @(posedge ref_clk);
      n++;
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge ref_clk); while (!bvalid && ++n < 1000);
    r = bresp;
    bready <= 0;
    if (n >= 1000) begin
      err_total++;
      $display("[FAIL] %0t: write timed out", $time);
    end
  endtask : wr

  task automatic rd(input logic [7:0] i);
    int n;
    n = 0;
    arvalid <= 1;
    araddr <= ba(i);
    do @(posedge ref_clk); while (!arready && ++n < 1000);
    arvalid <= 0;
    rready <= 1;
    do @(posedge ref_clk); while (!rvalid && ++n < 1000);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (n >= 1000) begin
      err_total++;
      $display("[FAIL] %0t: read timed out", $time);
    end
  endtask : rd

  task automatic alert_is(input logic e);
    repeat (3) @(posedge ref_clk);
    chk(alert_n, !e);
    chk(alert_oe, e);
  endtask : alert_is

  task automatic pulse(input logic [9:0] b);
    base <= b;
    fire <= 1;
    @(posedge ref_clk);
    fire <= 0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`IDX_ALERT_MASK_ONE);
    chk(d, 0);
    rd(`IDX_ALERT_MASK_TWO);
    chk(d, 0);
    chk(alert_n, 1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_access;
    wr(`IDX_ALERT_MASK_ONE, 32'h0000_00ff);
    chk(32'(r), 32'h0000_0000);
    rd(`IDX_ALERT_MASK_ONE);
    chk(d, 32'h0000_00f6);
    chk(32'(r), 32'h0000_0000);
    wr(`IDX_ALERT_MASK_TWO, 32'h0000_00ff);
    rd(`IDX_ALERT_MASK_TWO);
    chk(d, 32'h0000_00fc);
    rd(8'h00);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    chk(32'(r), 32'h0000_0002);
    wr(`IDX_ALERT_MASK_ONE, 0);
    wr(`IDX_ALERT_MASK_TWO, 0);
    $display("access test done");
  endtask : t_access

  task automatic t_limits;
    limit_events <= 5'h01;
    alert_is(0);
    wr(`IDX_ALERT_CONFIG, 1);
    alert_is(1);
    for (int i = 0; i < 5; i++) begin
      limit_events <= 5'(1 << i);
      wr(`IDX_ALERT_MASK_ONE, 1 << pos[i]);
      alert_is(0);
      wr(`IDX_ALERT_MASK_ONE, 0);
      alert_is(1);
    end
    limit_events <= '0;
    alert_is(0);
    $display("limit test done");
  endtask : t_limits

  task automatic t_faults;
    int m;
    for (int j = 1; j < 8; j++) begin
      m = (j < 5) ? j + 1 : j;
      tach_pin_is_thermal <= (j == 5);
      fault_events <= 8'(1 << j);
      wr(`IDX_ALERT_MASK_TWO, 1 << m);
      alert_is(0);
      wr(`IDX_ALERT_MASK_TWO, 0);
      alert_is(1);
    end
    tach_pin_is_thermal <= 1;
    fault_events <= 8'h10;
    alert_is(0);
    fault_events <= 8'h01;
    wr(`IDX_ALERT_MASK_TWO, 32'h0000_00ff);
    alert_is(1);
    fault_events <= 8'h02;
    alert_is(1);
    wr(`IDX_ALERT_MASK_ONE, 32'h0000_0080);
    alert_is(0);
    fault_events <= '0;
    wr(`IDX_ALERT_MASK_ONE, 0);
    wr(`IDX_ALERT_MASK_TWO, 0);
    $display("fault test done");
  endtask : t_faults

  task automatic t_freeze;
    logic [9:0] a, b, c;
    a = 10'h2d7;
    b = 10'h135;
    c = 10'h3a9;
    pulse(a);
    rd(`IDX_VOLTAGE_LOW_BITS);
    chk(d, {26'h0, 2'(v(a, 1)), 2'(v(a, 0)), 2'b00});
    pulse(b);
    rd(`IDX_HIGH_BYTE_BASE);
    chk(d, 32'(v(a, 0) >> 2));
    rd(`IDX_HIGH_BYTE_BASE + 8'h01);
    chk(d, 32'(v(a, 1) >> 2));
    rd(`IDX_TEMPERATURE_LOW_BITS);
    chk(d, {24'h0, 2'(v(b, 4)), 2'(v(b, 3)), 2'(v(b, 2)), 2'b00});
    pulse(c);
    rd(`IDX_HIGH_BYTE_BASE + 8'h03);
    chk(d, 32'(v(b, 3) >> 2));
    rd(`IDX_HIGH_BYTE_BASE);
    chk(d, 32'(v(c, 0) >> 2));
    // new sample lands on the edge of the low bits read
    base <= b;
    fire <= 1;
    @(posedge ref_clk);
    fire <= 0;
    rd(`IDX_VOLTAGE_LOW_BITS);
    chk(d, {26'h0, 2'(v(c, 1)), 2'(v(c, 0)), 2'b00});
    rd(`IDX_HIGH_BYTE_BASE + 8'h01);
    chk(d, 32'(v(c, 1) >> 2));
    $display("freeze test done");
  endtask : t_freeze

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    t_reset;
    t_access;
    t_limits;
    t_faults;
    t_freeze;
    end_of_test;
  end

  initial begin
    #400000;
    err_total++;
    end_of_test;
  end
endmodule : alert_mask_and_ext_resolution_bench
